// ### shared/bsc_consts.svh
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
// ==========================================
// Parallel port register map
`define BSC_PREG_CTRL 8'h0B
`define BSC_PREG_FLAGS 8'h0C
`define BSC_PIE_BIT 6
`define BSC_AIE_BIT 5
`define BSC_UIE_BIT 4
`define BSC_SQUARE_WAVE_ENABLE_BIT 3
`define BSC_CTRL_RST 8'h00
// ==========================================
// Bus-side registers
`define BSC_AXI_STATUS 8'h00
`define BSC_AXI_INT_STAT 8'h04
`define BSC_AXI_INT_MASK 8'h08
`define BSC_AXI_CFG 8'h0C
`define BSC_INT_WR_BIT 0
`define BSC_INT_RD_BIT 1
`define BSC_INT_RST_BIT 2
`define BSC_INT_REFUSE_BIT 3
`define BSC_CFG_RST 32'h0000_0001
`define BSC_RESP_OKAY 2'h0
`define BSC_RESP_SLVERR 2'h2
`endif

// ### shared/bsc_pkg.sv
package bsc_pkg;
    // Parallel port inputs, sampled on aclk
    typedef struct packed {
        logic [7:0] ad;
        logic address_strobe;
        logic read_or_data_strobe;
        logic write_n;
        logic chip_sel_n;
    } bsc_pbus_t;
    // Interrupt flag set
    typedef struct packed {
        logic periodic_flag;
        logic alarm_flag;
        logic update_flag;
    } bsc_flags_t;
endpackage

// ### rtl/bsc_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`include "bsc_consts.svh"

module bsc_top #(
    parameter int RAM_DEPTH = 128,
    parameter int AXI_AW = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic axi_irq,
    // Multiplexed parallel port
    input wire bsc_pkg::bsc_pbus_t pbus_i,
    output logic [7:0] ad_o,
    output logic ad_oe,
    input wire logic bus_style_select,
    input wire logic reset_in_n,
    input wire logic power_ok,
    // Timebase events and outputs
    input wire logic periodic_evt,
    input wire logic alarm_evt,
    input wire logic update_evt,
    input wire logic square_src,
    output logic square_wave_o,
    output logic irq_req_o,
    output logic irq_req_oe
);

    // ==========================================
    // Parameter checks
    initial begin
        if (RAM_DEPTH < 16 || RAM_DEPTH > 256) begin
            $error("RAM_DEPTH must be 16..256");
        end
        if (AXI_AW < 4) begin
            $error("AXI_AW must be at least 4");
        end
    end

    localparam int RAM_AW = $clog2(RAM_DEPTH);

    // ==========================================
    // Input edge history
    bsc_pkg::bsc_pbus_t pbus_q_reg;
    logic drive_q_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pbus_q_reg <= '{ad: 8'h00, address_strobe: 1'b0,
                read_or_data_strobe: 1'b0, write_n: 1'b1, chip_sel_n: 1'b1};
        end else begin
            pbus_q_reg <= pbus_i;
        end
    end

    // ==========================================
    // Reset pin qualification
    logic reset_apply;
    logic access_ok;
    logic host_en;

    assign reset_apply = !reset_in_n && power_ok;
    assign access_ok = reset_in_n && power_ok && host_en;

    // ==========================================
    // Address latch
    logic [7:0] addr_reg;
    logic addr_valid_reg;
    logic as_fall;
    logic as_rise;

    assign as_fall = pbus_q_reg.address_strobe && !pbus_i.address_strobe;
    assign as_rise = !pbus_q_reg.address_strobe && pbus_i.address_strobe;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_reg <= 8'h00;
            addr_valid_reg <= 1'b0;
        end else if (as_fall) begin
            addr_reg <= pbus_q_reg.ad;
            addr_valid_reg <= 1'b1;
        end else if (as_rise) begin
            addr_valid_reg <= 1'b0;
        end
    end

    // ==========================================
    // Strobe decode
    logic selected;
    logic drive;
    logic write_fire;
    logic read_done;
    logic strobe_edge;

    assign selected = addr_valid_reg && !pbus_i.chip_sel_n && access_ok;

    always_comb begin
        if (bus_style_select) begin
            drive = pbus_i.read_or_data_strobe && pbus_i.write_n;
            write_fire = pbus_q_reg.read_or_data_strobe
                && !pbus_i.read_or_data_strobe && !pbus_q_reg.write_n;
            strobe_edge = pbus_q_reg.read_or_data_strobe
                && !pbus_i.read_or_data_strobe;
        end else begin
            drive = !pbus_i.read_or_data_strobe && pbus_i.write_n;
            write_fire = !pbus_q_reg.write_n && pbus_i.write_n;
            strobe_edge = write_fire
                || (!pbus_q_reg.read_or_data_strobe && pbus_i.read_or_data_strobe);
        end
    end

    assign ad_oe = drive && selected;
    assign read_done = drive_q_reg && !ad_oe;

    logic write_ok;
    assign write_ok = write_fire && selected;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_q_reg <= 1'b0;
        end else begin
            drive_q_reg <= ad_oe;
        end
    end

    // ==========================================
    // Control register and RAM
    logic [7:0] ctrl_reg;
    logic [7:0] ram [RAM_DEPTH];
    logic addr_in_ram;

    assign addr_in_ram = 32'(addr_reg) < RAM_DEPTH;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `BSC_CTRL_RST;
        end else if (reset_apply) begin
            ctrl_reg[`BSC_PIE_BIT] <= 1'b0;
            ctrl_reg[`BSC_AIE_BIT] <= 1'b0;
            ctrl_reg[`BSC_UIE_BIT] <= 1'b0;
            ctrl_reg[`BSC_SQUARE_WAVE_ENABLE_BIT] <= 1'b0;
        end else if (write_ok && addr_reg == `BSC_PREG_CTRL) begin
            ctrl_reg <= pbus_q_reg.ad;
        end
    end

    always_ff @(posedge aclk) begin
        if (write_ok && addr_in_ram && addr_reg != `BSC_PREG_CTRL
                && addr_reg != `BSC_PREG_FLAGS) begin
            ram[addr_reg[RAM_AW-1:0]] <= pbus_q_reg.ad;
        end
    end

    // ==========================================
    // Interrupt flags
    bsc_pkg::bsc_flags_t flags_reg;
    logic any_irq_flag;
    logic flags_rd_clr;

    assign flags_rd_clr = read_done && addr_reg == `BSC_PREG_FLAGS;

    // Events win over a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= '0;
        end else if (reset_apply) begin
            flags_reg <= '0;
        end else begin
            flags_reg.periodic_flag <= periodic_evt
                || (flags_reg.periodic_flag && !flags_rd_clr);
            flags_reg.alarm_flag <= alarm_evt
                || (flags_reg.alarm_flag && !flags_rd_clr);
            flags_reg.update_flag <= update_evt
                || (flags_reg.update_flag && !flags_rd_clr);
        end
    end

    assign any_irq_flag =
        (flags_reg.periodic_flag && ctrl_reg[`BSC_PIE_BIT])
        || (flags_reg.alarm_flag && ctrl_reg[`BSC_AIE_BIT])
        || (flags_reg.update_flag && ctrl_reg[`BSC_UIE_BIT]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req_oe <= 1'b0;
        end else begin
            irq_req_oe <= any_irq_flag && !reset_apply && !flags_rd_clr;
        end
    end
    assign irq_req_o = 1'b0;

    // Square wave dies with the supply too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            square_wave_o <= 1'b0;
        end else begin
            square_wave_o <= square_src && ctrl_reg[`BSC_SQUARE_WAVE_ENABLE_BIT] && power_ok;
        end
    end

    // ==========================================
    // Read data
    logic [7:0] read_mux;

    always_comb begin
        if (addr_reg == `BSC_PREG_CTRL) begin
            read_mux = ctrl_reg;
        end else if (addr_reg == `BSC_PREG_FLAGS) begin
            read_mux = {any_irq_flag, flags_reg, 4'h0};
        end else if (addr_in_ram) begin
            read_mux = ram[addr_reg[RAM_AW-1:0]];
        end else begin
            read_mux = 8'h00;
        end
    end

    // Frozen while driving so a read-clear cannot alter the byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ad_o <= 8'h00;
        end else if (!ad_oe) begin
            ad_o <= read_mux;
        end
    end

    // ==========================================
    // Bus-side interrupt status
    logic [3:0] int_stat_reg;
    logic [3:0] int_mask_reg;
    logic [31:0] cfg_reg;
    logic [3:0] int_evt;
    logic [3:0] int_w1c;
    logic reset_apply_q_reg;
    logic refused;

    assign host_en = cfg_reg[0];
    assign refused = strobe_edge && addr_valid_reg && !pbus_i.chip_sel_n
        && !access_ok;

    always_comb begin
        int_evt = 4'h0;
        int_evt[`BSC_INT_WR_BIT] = write_ok;
        int_evt[`BSC_INT_RD_BIT] = read_done;
        int_evt[`BSC_INT_RST_BIT] = reset_apply && !reset_apply_q_reg;
        int_evt[`BSC_INT_REFUSE_BIT] = refused;
    end

    logic wr_go;
    logic [AXI_AW-1:0] waddr;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign waddr = s_axi_awaddr;
    assign int_w1c = (wr_go && waddr == AXI_AW'(`BSC_AXI_INT_STAT)
        && s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_apply_q_reg <= 1'b0;
            int_stat_reg <= 4'h0;
        end else begin
            reset_apply_q_reg <= reset_apply;
            int_stat_reg <= int_evt | (int_stat_reg & ~int_w1c);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_mask_reg <= 4'h0;
            cfg_reg <= `BSC_CFG_RST;
        end else if (wr_go && s_axi_wstrb[0]) begin
            if (waddr == AXI_AW'(`BSC_AXI_INT_MASK)) begin
                int_mask_reg <= s_axi_wdata[3:0];
            end
            if (waddr == AXI_AW'(`BSC_AXI_CFG)) begin
                cfg_reg <= {31'h0000_0000, s_axi_wdata[0]};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            axi_irq <= 1'b0;
        end else begin
            axi_irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // ==========================================
    // AXI write response
    logic wr_mapped;
    assign wr_mapped = waddr == AXI_AW'(`BSC_AXI_INT_STAT)
        || waddr == AXI_AW'(`BSC_AXI_INT_MASK)
        || waddr == AXI_AW'(`BSC_AXI_CFG)
        || waddr == AXI_AW'(`BSC_AXI_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BSC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `BSC_RESP_OKAY : `BSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // AXI read
    logic [31:0] status_word;
    assign status_word = {16'h0000, ctrl_reg, any_irq_flag, flags_reg,
        reset_apply, !reset_in_n, power_ok, bus_style_select};
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `BSC_RESP_OKAY;
            unique case (s_axi_araddr)
                AXI_AW'(`BSC_AXI_STATUS): s_axi_rdata <= status_word;
                AXI_AW'(`BSC_AXI_INT_STAT): s_axi_rdata <= {28'h0, int_stat_reg};
                AXI_AW'(`BSC_AXI_INT_MASK): s_axi_rdata <= {28'h0, int_mask_reg};
                AXI_AW'(`BSC_AXI_CFG): s_axi_rdata <= cfg_reg;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `BSC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // bsc_top

// ### tb/bsc_chk.sv
`include "bsc_consts.svh"

module bsc_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Parallel port
    input wire bsc_pkg::bsc_pbus_t pbus_i,
    input wire logic ad_oe,
    input wire logic bus_style_select,
    input wire logic reset_in_n,
    input wire logic power_ok,
    input wire logic square_wave_o,
    input wire logic irq_req_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic rst_apply;
    assign rst_apply = !reset_in_n && power_ok;
    sequence s_rst2;
        rst_apply [*2];
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    // ====
    // Parallel port
    // read phase only
    AST_OE_STYLE: assert property (ad_oe |-> pbus_i.read_or_data_strobe == bus_style_select
        && pbus_i.write_n && !pbus_i.chip_sel_n) else $error("bus driven outside read phase");
    AST_OE_BLOCK: assert property (!(reset_in_n && power_ok) |-> !ad_oe)
        else $error("bus driven while blocked");
    AST_IRQ_REL: assert property (rst_apply |=> !irq_req_oe)
        else $error("interrupt held during reset");
    AST_SQW_OFF: assert property (s_rst2 |=> !square_wave_o)
        else $error("square output runs during reset");
    AST_SQW_GATE: assert property (!power_ok |=> !square_wave_o)
        else $error("square output with supply low");
    // ====
    // Register bus
    AST_WR_ANS: assert property (s_wr_take |=> s_axi_bvalid)
        else $error("write answer late");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    AST_RD_ANS: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read answer late");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `BSC_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read with data");
endmodule // bsc_chk

bind bsc_top bsc_chk u_bsc_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .pbus_i(pbus_i), .ad_oe(ad_oe),
    .bus_style_select(bus_style_select), .reset_in_n(reset_in_n), .power_ok(power_ok),
    .square_wave_o(square_wave_o), .irq_req_oe(irq_req_oe));

// ### tb/bsc_host_model.sv
module bsc_host_model (
    // Clock and style
    input wire logic aclk,
    input wire logic bus_style_select,
    // Device side of the AD lines
    input wire logic [7:0] ad_o,
    input wire logic ad_oe,
    // Pins toward the device
    output bsc_pkg::bsc_pbus_t pbus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b0;
    logic [7:0] val = 8'h00;
    logic as_r = 1'b0;
    logic ds_act = 1'b0;
    logic wn = 1'b1;
    logic csn = 1'b1;
    // Released lines show the inverse byte, never a stale copy
    always_comb begin
        pbus.ad = ad_oe ? ad_o : (drv ? val : ~val);
        pbus.address_strobe = as_r;
        pbus.read_or_data_strobe = bus_style_select ? ds_act : !ds_act;
        pbus.write_n = wn;
        pbus.chip_sel_n = csn;
    end
    // Fresh address strobe ahead of every access
    task automatic addr_phase(input logic [7:0] a, input logic cs);
        @(posedge aclk);
        csn <= !cs;
        drv <= 1'b1;
        val <= a;
        as_r <= 1'b1;
        repeat (2) @(posedge aclk);
        as_r <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic pwrite(input logic [7:0] a, input logic [7:0] d, input logic cs);
        addr_phase(a, cs);
        val <= d;
        wn <= 1'b0;
        ds_act <= bus_style_select;
        repeat (2) @(posedge aclk);
        wn <= 1'b1;
        ds_act <= 1'b0;
        @(posedge aclk);
        drv <= 1'b0;
        csn <= 1'b1;
        @(posedge aclk);
    endtask
    task automatic pread(input logic [7:0] a, output logic [7:0] d);
        addr_phase(a, 1'b1);
        drv <= 1'b0;
        ds_act <= 1'b1;
        repeat (2) @(posedge aclk);
        d = pbus.ad;
        ds_act <= 1'b0;
        csn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
endmodule // bsc_host_model

// ### tb/bsc_tb_top.sv
`include "bsc_consts.svh"

module bsc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, ad_o, rb;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, axi_irq, ad_oe, sq_o, irq_o, irq_oe;
    logic [1:0] bresp, rresp;
    logic style = 1'b1, rst_n = 1'b1, pwr_ok = 1'b1, sq_src = 1'b1;
    logic [2:0] evt = 3'h0;
    bsc_pkg::bsc_pbus_t pbus;
    int bad_count = 0;
    int check_count = 0;

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    bsc_top u_bsc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .axi_irq(axi_irq),
        .pbus_i(pbus), .ad_o(ad_o), .ad_oe(ad_oe), .bus_style_select(style),
        .reset_in_n(rst_n), .power_ok(pwr_ok), .periodic_evt(evt[2]), .alarm_evt(evt[1]),
        .update_evt(evt[0]), .square_src(sq_src), .square_wave_o(sq_o), .irq_req_o(irq_o),
        .irq_req_oe(irq_oe));

    bsc_host_model u_bsc_host_model (.aclk(aclk), .bus_style_select(style), .ad_o(ad_o),
        .ad_oe(ad_oe), .pbus(pbus));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ====
    // Register bus master
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Each channel let go on its own ready
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && awready === 1'b1) begin
                aw_left = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_left && wready === 1'b1) begin
                w_left = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check(bresp, r);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        check(rdata, d);
        check(rresp, r);
    endtask

    task automatic prd_chk(input logic [7:0] a, input logic [7:0] e);
        u_bsc_host_model.pread(a, rb);
        check(rb, e);
    endtask

    task automatic fire;
        evt <= 3'h7;
        @(posedge aclk);
        evt <= 3'h0;
        repeat (3) @(posedge aclk);
    endtask

    // ====
    // Scenarios
    initial begin
        // pin high from power-up, so no long hold is owed
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`BSC_AXI_CFG, `BSC_CFG_RST, `BSC_RESP_OKAY);
        axi_rd(8'h10, 32'h0, `BSC_RESP_SLVERR);
        axi_wr(`BSC_AXI_INT_MASK, 32'h1, `BSC_RESP_OKAY);
        axi_wr(`BSC_AXI_INT_STAT, 32'hF, `BSC_RESP_OKAY);
        u_bsc_host_model.pwrite(`BSC_PREG_CTRL, 8'h78, 1'b1);
        repeat (2) @(posedge aclk);
        check(axi_irq, 1'b1);
        axi_rd(`BSC_AXI_INT_STAT, 32'h1, `BSC_RESP_OKAY);
        axi_wr(`BSC_AXI_INT_STAT, 32'h1, `BSC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(axi_irq, 1'b0);
        prd_chk(`BSC_PREG_CTRL, 8'h78);
        check(sq_o, 1'b1);
        style <= 1'b0;
        u_bsc_host_model.pwrite(8'h20, 8'hA5, 1'b1);
        prd_chk(8'h20, 8'hA5);
        u_bsc_host_model.pwrite(8'h20, 8'h11, 1'b0);
        prd_chk(8'h20, 8'hA5);
        style <= 1'b1;
        fire();
        check(irq_oe, 1'b1);
        prd_chk(`BSC_PREG_FLAGS, 8'hF0);
        repeat (2) @(posedge aclk);
        check(irq_oe, 1'b0);
        prd_chk(`BSC_PREG_FLAGS, 8'h00);
        u_bsc_host_model.pwrite(8'h21, 8'h5A, 1'b1);
        fire();
        axi_wr(`BSC_AXI_INT_STAT, 32'hF, `BSC_RESP_OKAY);
        rst_n <= 1'b0;
        u_bsc_host_model.pwrite(8'h21, 8'h00, 1'b1);
        check(irq_oe, 1'b0);
        check(irq_o, 1'b0);
        check(sq_o, 1'b0);
        rst_n <= 1'b1;
        axi_rd(`BSC_AXI_INT_STAT, 32'hC, `BSC_RESP_OKAY);
        prd_chk(`BSC_PREG_CTRL, 8'h00);
        prd_chk(`BSC_PREG_FLAGS, 8'h00);
        prd_chk(8'h21, 8'h5A);
        u_bsc_host_model.pwrite(`BSC_PREG_CTRL, 8'h78, 1'b1);
        pwr_ok <= 1'b0;
        repeat (2) @(posedge aclk);
        rst_n <= 1'b0;
        repeat (4) @(posedge aclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge aclk);
        check(sq_o, 1'b0);
        pwr_ok <= 1'b1;
        prd_chk(`BSC_PREG_CTRL, 8'h78);
        // Status word: control byte, no flags, supply good, strobe style
        axi_rd(`BSC_AXI_STATUS, 32'h0000_7803, `BSC_RESP_OKAY);
        axi_wr(8'h14, 32'h0, `BSC_RESP_SLVERR);
        axi_wr(`BSC_AXI_INT_STAT, 32'hF, `BSC_RESP_OKAY);
        // Host port disabled by config: strobe refused, byte kept
        axi_wr(`BSC_AXI_CFG, 32'h0, `BSC_RESP_OKAY);
        u_bsc_host_model.pwrite(8'h21, 8'h00, 1'b1);
        axi_rd(`BSC_AXI_INT_STAT, 32'h8, `BSC_RESP_OKAY);
        axi_wr(`BSC_AXI_CFG, 32'h1, `BSC_RESP_OKAY);
        prd_chk(8'h21, 8'h5A);
        print_verdict();
    end

    // Tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        print_verdict();
    end
endmodule // bsc_tb_top
